// *** rtl/sdid_top.sv ***
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// RL1: Servo enable gives servo ready, all modes
// RL2: Fault reset clears resettable faults
// RL3: Pulse clear runs selected clear mode
// RL4: Zero clamp below range holds position
// RL5: Command invert reverses in torque/speed
// RL6: Torque limit enable validates limit, speed
// RL7: Speed limit enable validates limit, torque
// RL8: Two selector bits pick speed source
// RL9: Two selector bits pick torque source
// RL10: Position-speed mode switch: off speed, on position
// RL11: Speed-torque mode switch: off speed, on torque
// RL12: Torque-position mode switch: off torque, on position
// RL13: Emergency stop open raises fault
// RL14: Reverse inhibit open raises fault
// RL15: Forward inhibit open raises fault
// RL16: Torque limit inputs need function setting
// RL17: Forward jog while active
// RL18: Reverse jog while active
// RL19: Gear selectors index numerator in MODE_PT and MODE_PT_S only
// RL20: Pulse inhibit drops external pulses
// RL21: Terminal map assigns functions and polarity
// RL22: Inputs pass two-stage synchroniser first
module sdid_top (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire sdid_pkg::sdid_apb_req_t apb_i,
    output sdid_pkg::sdid_apb_rsp_t apb_o,
    input wire logic [sdid_pkg::DI_NUM-1:0] di_pins_i,
    input wire logic [sdid_pkg::CMD_W-1:0] motor_speed_i,
    input wire logic [sdid_pkg::CMD_W-1:0] analog_speed_i,
    input wire logic [sdid_pkg::CMD_W-1:0] analog_torque_i,
    output sdid_pkg::sdid_cmd_t cmd_o
);
    import sdid_pkg::*;

    typedef logic [DI_NUM-1:0][MAP_W-1:0] sdid_map_t;

    // Function is on when a terminal carries its code at the active level
    function automatic logic fn_on(input logic [7:0] code, input logic [DI_NUM-1:0] lvl,
                                   input sdid_map_t map);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < DI_NUM; i++) begin
            if (map[i][7:0] == code && lvl[i] == map[i][MAP_W-1]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    function automatic logic fn_mapped(input logic [7:0] code, input sdid_map_t map);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < DI_NUM; i++) begin
            if (map[i][7:0] == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Normally closed contact: healthy while on, or while no terminal carries it
    function automatic logic fn_closed(input logic [7:0] code, input logic [DI_NUM-1:0] lvl,
                                       input sdid_map_t map);
        return fn_on(code, lvl, map) | ~fn_mapped(code, map);
    endfunction

    logic [DI_NUM-1:0] pins;

    sdid_sync #(
        .WIDTH(DI_NUM)
    ) u_sync (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .async_i(di_pins_i), // RL22
        .sync_o(pins)
    );

    // Configuration registers
    logic [5:0] ctrl_r;
    logic [5:0] ctrl_nxt;
    logic [CMD_W-1:0] zero_range_r;
    logic [CMD_W-1:0] zero_range_nxt;

    sdid_map_t assign_r;
    sdid_map_t assign_nxt;
    logic [PRESET_NUM-1:0][CMD_W-1:0] spd_preset_r;
    logic [PRESET_NUM-1:0][CMD_W-1:0] spd_preset_nxt;
    logic [PRESET_NUM-1:0][CMD_W-1:0] trq_preset_r;
    logic [PRESET_NUM-1:0][CMD_W-1:0] trq_preset_nxt;
    logic [GEAR_NUM-1:0][CMD_W-1:0] gear_r;
    logic [GEAR_NUM-1:0][CMD_W-1:0] gear_nxt;

    sdid_apb_rsp_t rsp_r;
    sdid_apb_rsp_t rsp_nxt;
    sdid_cmd_t cmd_r;
    sdid_cmd_t cmd_nxt;
    logic fault_reset_prev_r;
    logic fault_reset_prev_nxt;
    logic pulse_clear_prev_r;
    logic pulse_clear_prev_nxt;

    logic [FAULT_NUM-1:0] faults;
    logic [FAULT_NUM-1:0] closed;
    logic fault_reset_on;
    logic fault_reset_edge;
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [1:0] sub_idx;
    logic [2:0] map_idx;
    logic in_assign;
    logic in_spd;
    logic in_trq;
    logic in_gear;
    sdid_mode_t mode;

    assign mode = sdid_mode_t'(ctrl_r[CTRL_MODE_LSB +: 3]);
    assign addr = apb_i.paddr;
    assign map_idx = addr[4:2];
    assign sub_idx = addr[3:2];
    assign in_assign = addr[ADDR_W-1:5] == REG_ASSIGN_BASE[ADDR_W-1:5] && addr[1:0] == 2'h0;
    assign in_spd = addr[ADDR_W-1:4] == REG_SPD_BASE[ADDR_W-1:4] && addr[1:0] == 2'h0
        && sub_idx < 2'(PRESET_NUM);
    assign in_trq = addr[ADDR_W-1:4] == REG_TRQ_BASE[ADDR_W-1:4] && addr[1:0] == 2'h0
        && sub_idx < 2'(PRESET_NUM);
    assign in_gear = addr[ADDR_W-1:4] == REG_GEAR_BASE[ADDR_W-1:4] && addr[1:0] == 2'h0;

    assign wr_en = apb_i.psel & apb_i.penable & apb_i.pwrite & rsp_r.pready;

    assign closed[0] = fn_closed(FN_EMERGENCY_STOP, pins, assign_r); // RL13
    assign closed[1] = fn_closed(FN_REV_INHIBIT, pins, assign_r); // RL14
    assign closed[2] = fn_closed(FN_FWD_INHIBIT, pins, assign_r); // RL15
    // A held reset input clears only once
    assign fault_reset_on = fn_on(FN_FAULT_RESET, pins, assign_r);
    assign fault_reset_edge = fault_reset_on & ~fault_reset_prev_r;

    sdid_fault #(
        .NUM(FAULT_NUM)
    ) u_fault (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .closed_i(closed),
        .clear_i(fault_reset_edge), // RL2
        .fault_o(faults)
    );

    // Register writes land in the access cycle
    always_comb begin
        ctrl_nxt = ctrl_r;
        zero_range_nxt = zero_range_r;
        assign_nxt = assign_r;
        spd_preset_nxt = spd_preset_r;
        trq_preset_nxt = trq_preset_r;
        gear_nxt = gear_r;
        if (wr_en) begin
            if (addr == REG_CTRL) begin
                ctrl_nxt = apb_i.pwdata[5:0];
            end else if (addr == REG_ZERO_RANGE) begin
                zero_range_nxt = apb_i.pwdata[CMD_W-1:0];
            end else if (in_assign) begin
                assign_nxt[map_idx] = apb_i.pwdata[MAP_W-1:0]; // RL21
            end else if (in_spd) begin
                spd_preset_nxt[sub_idx] = apb_i.pwdata[CMD_W-1:0];
            end else if (in_trq) begin
                trq_preset_nxt[sub_idx] = apb_i.pwdata[CMD_W-1:0];
            end else if (in_gear) begin
                gear_nxt[sub_idx] = apb_i.pwdata[CMD_W-1:0];
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_r <= CTRL_RST;
            zero_range_r <= ZERO_RANGE_RST;
            assign_r <= ASSIGN_RST;
            spd_preset_r <= {PRESET_NUM{PRESET_RST}};
            trq_preset_r <= {PRESET_NUM{PRESET_RST}};
            gear_r <= {GEAR_NUM{GEAR_RST}};
        end else begin
            ctrl_r <= ctrl_nxt;
            zero_range_r <= zero_range_nxt;
            assign_r <= assign_nxt;
            spd_preset_r <= spd_preset_nxt;
            trq_preset_r <= trq_preset_nxt;
            gear_r <= gear_nxt;
        end
    end

    // Read data prepared in the setup cycle, ready one cycle later
    always_comb begin
        rsp_nxt = '0;
        if (apb_i.psel && !apb_i.penable) begin
            rsp_nxt.pready = 1'b1;
            if (addr == REG_CTRL) begin
                rsp_nxt.prdata = {26'h000_0000, ctrl_r};
            end else if (addr == REG_ZERO_RANGE) begin
                rsp_nxt.prdata = {16'h0000, zero_range_r};
            end else if (addr == REG_STATUS) begin
                rsp_nxt.prdata = {24'h00_0000, cmd_r.fault_indication, cmd_r.position_hold,
                    cmd_r.ctl, cmd_r.servo_ready, faults};
            end else if (addr == REG_PINS) begin
                rsp_nxt.prdata = {24'h00_0000, pins};
            end else if (in_assign) begin
                rsp_nxt.prdata = {23'h00_0000, assign_r[map_idx]};
            end else if (in_spd) begin
                rsp_nxt.prdata = {16'h0000, spd_preset_r[sub_idx]};
            end else if (in_trq) begin
                rsp_nxt.prdata = {16'h0000, trq_preset_r[sub_idx]};
            end else if (in_gear) begin
                rsp_nxt.prdata = {16'h0000, gear_r[sub_idx]};
            end else begin
                rsp_nxt.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    // Function decode into drive commands
    always_comb begin
        logic [1:0] spd_sel;
        logic [1:0] trq_sel;
        logic [1:0] gear_sel;
        logic pulse_clear_on;
        logic clr_level;
        logic [CMD_W-1:0] speed_mag;
        logic jog_f;
        logic jog_r;

        spd_sel = {fn_on(FN_SPD_SEL_HI, pins, assign_r), fn_on(FN_SPD_SEL_LO, pins, assign_r)};
        trq_sel = {fn_on(FN_TRQ_SEL_HI, pins, assign_r), fn_on(FN_TRQ_SEL_LO, pins, assign_r)};
        gear_sel = {fn_on(FN_GEAR_SEL_HI, pins, assign_r), fn_on(FN_GEAR_SEL_LO, pins, assign_r)};
        pulse_clear_on = fn_on(FN_PULSE_CLEAR, pins, assign_r);
        clr_level = ctrl_r[CTRL_CLR_LSB];
        // Signed speed to magnitude
        speed_mag = motor_speed_i[CMD_W-1] ? CMD_W'(-motor_speed_i) : motor_speed_i;
        jog_f = fn_on(FN_FWD_JOG, pins, assign_r);
        jog_r = fn_on(FN_REV_JOG, pins, assign_r);
        fault_reset_prev_nxt = fault_reset_on;
        pulse_clear_prev_nxt = pulse_clear_on;
        cmd_nxt = cmd_r;

        unique case (mode)
            MODE_PT: cmd_nxt.ctl = CTL_POS;
            MODE_S, MODE_SZ: cmd_nxt.ctl = CTL_SPD;
            MODE_T, MODE_TZ: cmd_nxt.ctl = CTL_TRQ;
            MODE_PT_S: begin
                cmd_nxt.ctl = fn_on(FN_SW_POS_SPD, pins, assign_r) ? CTL_POS : CTL_SPD; // RL10
            end
            MODE_S_T: begin
                cmd_nxt.ctl = fn_on(FN_SW_SPD_TRQ, pins, assign_r) ? CTL_TRQ : CTL_SPD; // RL11
            end
            MODE_PT_T: begin
                cmd_nxt.ctl = fn_on(FN_SW_TRQ_POS, pins, assign_r) ? CTL_POS : CTL_TRQ; // RL12
            end
        endcase

        cmd_nxt.fault_clear = fault_reset_edge; // RL2
        cmd_nxt.fault_flags = faults;
        cmd_nxt.fault_indication = |faults; // RL13 RL14 RL15
        cmd_nxt.servo_ready = fn_on(FN_SERVO_ENABLE, pins, assign_r) & ~(|faults); // RL1

        // Selector pairs read {hi, lo}
        unique case (spd_sel)
            2'b00: cmd_nxt.speed_cmd = (mode == MODE_SZ) ? '0 : analog_speed_i; // RL8
            2'b01: cmd_nxt.speed_cmd = spd_preset_r[0];
            2'b10: cmd_nxt.speed_cmd = spd_preset_r[1];
            2'b11: cmd_nxt.speed_cmd = spd_preset_r[2];
        endcase
        unique case (trq_sel)
            2'b00: cmd_nxt.torque_cmd = (mode == MODE_TZ) ? '0 : analog_torque_i; // RL9
            2'b01: cmd_nxt.torque_cmd = trq_preset_r[0];
            2'b10: cmd_nxt.torque_cmd = trq_preset_r[1];
            2'b11: cmd_nxt.torque_cmd = trq_preset_r[2];
        endcase

        cmd_nxt.torque_limit_valid = (cmd_nxt.ctl == CTL_SPD)
            & fn_on(FN_TRQ_LIMIT_EN, pins, assign_r); // RL6
        cmd_nxt.speed_limit_valid = (cmd_nxt.ctl == CTL_TRQ)
            & fn_on(FN_SPD_LIMIT_EN, pins, assign_r); // RL7
        cmd_nxt.direction_invert = (cmd_nxt.ctl != CTL_POS)
            & fn_on(FN_CMD_INVERT, pins, assign_r); // RL5
        cmd_nxt.position_hold = fn_on(FN_ZERO_CLAMP, pins, assign_r)
            & (speed_mag < zero_range_r); // RL4

        // Opposing jog requests cancel each other
        cmd_nxt.jog_fwd = jog_f & ~jog_r; // RL17
        cmd_nxt.jog_rev = jog_r & ~jog_f; // RL18

        cmd_nxt.fwd_torque_limit = ctrl_r[CTRL_TLF_BIT]
            & fn_on(FN_FWD_TRQ_LIMIT, pins, assign_r); // RL16
        cmd_nxt.rev_torque_limit = ctrl_r[CTRL_TLF_BIT]
            & fn_on(FN_REV_TRQ_LIMIT, pins, assign_r); // RL16

        if (mode == MODE_PT || mode == MODE_PT_S) begin
            cmd_nxt.gear_numerator = gear_r[gear_sel]; // RL19
        end else begin
            cmd_nxt.gear_numerator = gear_r[0];
        end

        cmd_nxt.pulse_inhibit = (cmd_nxt.ctl == CTL_POS)
            & fn_on(FN_PULSE_INHIBIT, pins, assign_r); // RL20

        // Edge mode gives one pulse, level mode follows the input
        if (cmd_nxt.ctl == CTL_POS) begin
            cmd_nxt.pulse_clear = clr_level ? pulse_clear_on
                : (pulse_clear_on & ~pulse_clear_prev_r); // RL3
        end else begin
            cmd_nxt.pulse_clear = 1'b0;
        end

        cmd_nxt.pulse_clear_kind = ctrl_r[CTRL_CLR_LSB+1]; // RL3
        cmd_nxt.gain_switch = fn_on(FN_GAIN_SWITCH, pins, assign_r);
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_r <= '0;
            fault_reset_prev_r <= 1'b0;
            pulse_clear_prev_r <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            fault_reset_prev_r <= fault_reset_prev_nxt;
            pulse_clear_prev_r <= pulse_clear_prev_nxt;
        end
    end

    assign apb_o = rsp_r;
    assign cmd_o = cmd_r;
endmodule

`default_nettype wire

// *** common/sdid_pkg.sv ***
package sdid_pkg;

    localparam int unsigned DI_NUM = 8;
    localparam int unsigned CMD_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned MAP_W = 9;
    localparam int unsigned FAULT_NUM = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_ZERO_RANGE = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_PINS = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_ASSIGN_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] REG_SPD_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] REG_TRQ_BASE = 8'h50;
    localparam logic [ADDR_W-1:0] REG_GEAR_BASE = 8'h60;
    localparam int unsigned PRESET_NUM = 3;
    localparam int unsigned GEAR_NUM = 4;

    // Control register fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_CLR_LSB = 3;
    localparam int unsigned CTRL_TLF_BIT = 5;

    // Reset values
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [CMD_W-1:0] ZERO_RANGE_RST = 16'h000A;
    localparam logic [CMD_W-1:0] PRESET_RST = 16'h0000;
    localparam logic [CMD_W-1:0] GEAR_RST = 16'h0001;

    // Input function codes
    localparam logic [7:0] FN_SERVO_ENABLE = 8'h01;
    localparam logic [7:0] FN_FAULT_RESET = 8'h02;
    localparam logic [7:0] FN_GAIN_SWITCH = 8'h03;
    localparam logic [7:0] FN_PULSE_CLEAR = 8'h04;
    localparam logic [7:0] FN_ZERO_CLAMP = 8'h05;
    localparam logic [7:0] FN_CMD_INVERT = 8'h06;
    localparam logic [7:0] FN_TRQ_LIMIT_EN = 8'h09;
    localparam logic [7:0] FN_SPD_LIMIT_EN = 8'h10;
    localparam logic [7:0] FN_SPD_SEL_LO = 8'h14;
    localparam logic [7:0] FN_SPD_SEL_HI = 8'h15;
    localparam logic [7:0] FN_TRQ_SEL_LO = 8'h16;
    localparam logic [7:0] FN_TRQ_SEL_HI = 8'h17;
    localparam logic [7:0] FN_SW_POS_SPD = 8'h18;
    localparam logic [7:0] FN_SW_SPD_TRQ = 8'h19;
    localparam logic [7:0] FN_SW_TRQ_POS = 8'h20;
    localparam logic [7:0] FN_EMERGENCY_STOP = 8'h21;
    localparam logic [7:0] FN_REV_INHIBIT = 8'h22;
    localparam logic [7:0] FN_FWD_INHIBIT = 8'h23;
    localparam logic [7:0] FN_REV_TRQ_LIMIT = 8'h25;
    localparam logic [7:0] FN_FWD_TRQ_LIMIT = 8'h26;
    localparam logic [7:0] FN_FWD_JOG = 8'h37;
    localparam logic [7:0] FN_REV_JOG = 8'h38;
    localparam logic [7:0] FN_GEAR_SEL_LO = 8'h43;
    localparam logic [7:0] FN_GEAR_SEL_HI = 8'h44;
    localparam logic [7:0] FN_PULSE_INHIBIT = 8'h45;

    // Terminal map after reset: {active high, code}, terminal 1 in the low slot
    localparam logic [DI_NUM-1:0][MAP_W-1:0] ASSIGN_RST = {
        9'h121, 9'h123, 9'h122, 9'h102, 9'h117, 9'h116, 9'h104, 9'h101};

    typedef enum logic [2:0] {
        MODE_PT, MODE_S, MODE_T, MODE_SZ, MODE_TZ, MODE_PT_S, MODE_PT_T, MODE_S_T
    } sdid_mode_t;

    typedef enum logic [1:0] {CTL_POS, CTL_SPD, CTL_TRQ} sdid_ctl_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } sdid_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sdid_apb_rsp_t;

    typedef struct packed {
        logic servo_ready;
        logic fault_indication;
        logic [FAULT_NUM-1:0] fault_flags;
        logic fault_clear;
        sdid_ctl_t ctl;
        logic [CMD_W-1:0] speed_cmd;
        logic [CMD_W-1:0] torque_cmd;
        logic speed_limit_valid;
        logic torque_limit_valid;
        logic direction_invert;
        logic position_hold;
        logic jog_fwd;
        logic jog_rev;
        logic fwd_torque_limit;
        logic rev_torque_limit;
        logic [CMD_W-1:0] gear_numerator;
        logic pulse_inhibit;
        logic pulse_clear;
        logic pulse_clear_kind;
        logic gain_switch;
    } sdid_cmd_t;

endpackage

// *** rtl/sdid_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

module sdid_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stable_r;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_r <= '0;
            stable_r <= '0;
        end else begin
            meta_r <= async_i;
            stable_r <= meta_r;
        end
    end

    assign sync_o = stable_r;
endmodule

`default_nettype wire

// *** rtl/sdid_fault.sv ***
`timescale 1ns/1ns
`default_nettype none

module sdid_fault #(
    parameter int unsigned NUM = 3
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [NUM-1:0] closed_i,
    input wire logic clear_i,
    output logic [NUM-1:0] fault_o
);
    logic [NUM-1:0] fault_r;
    logic [NUM-1:0] fault_nxt;

    // An open contact keeps setting its flag, so a clear only holds once closed
    always_comb begin
        fault_nxt = (fault_r & ~{NUM{clear_i}}) | ~closed_i; // RL2 RL13 RL14 RL15
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fault_r <= '0;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    assign fault_o = fault_r;
endmodule

`default_nettype wire

// *** bench/sdid_top_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module sdid_top_assertions (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire sdid_pkg::sdid_apb_req_t apb_i,
    input wire sdid_pkg::sdid_apb_rsp_t apb_o,
    input wire logic [sdid_pkg::DI_NUM-1:0] di_pins_i,
    input wire logic [sdid_pkg::CMD_W-1:0] motor_speed_i,
    input wire logic [sdid_pkg::CMD_W-1:0] analog_speed_i,
    input wire logic [sdid_pkg::CMD_W-1:0] analog_torque_i,
    input wire sdid_pkg::sdid_cmd_t cmd_o
);
    import sdid_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence s_setup;
        apb_i.psel && !apb_i.penable;
    endsequence
    sequence s_access;
        apb_i.psel && apb_i.penable && apb_o.pready;
    endsequence
    AST_APB_READY: assert property (s_setup |=> s_access)
        else $error("no ready after setup");
    AST_APB_ONE: assert property (apb_o.pready |=> !apb_o.pready)
        else $error("ready longer than one cycle");
    AST_APB_ERR: assert property (apb_o.pslverr |-> apb_o.pready && apb_o.prdata == '0)
        else $error("error without ready or with data");
    AST_FLT_EMG: assert property ($rose(cmd_o.fault_flags[0]) |-> cmd_o.fault_indication)
        else $error("stop fault not indicated");
    AST_FLT_REV: assert property ($rose(cmd_o.fault_flags[1]) |-> cmd_o.fault_indication)
        else $error("reverse fault not indicated");
    AST_FLT_FWD: assert property ($rose(cmd_o.fault_flags[2]) |-> cmd_o.fault_indication)
        else $error("forward fault not indicated");
    AST_RDY_FAULT: assert property (cmd_o.fault_indication |-> ##[0:2] !cmd_o.servo_ready)
        else $error("ready while faulted");
    AST_JOG_EXCL: assert property (!(cmd_o.jog_fwd && cmd_o.jog_rev))
        else $error("both jogs on");
    AST_CLR_PULSE: assert property (cmd_o.fault_clear |=> !cmd_o.fault_clear)
        else $error("fault clear too long");
    AST_CTL_LEGAL: assert property (cmd_o.ctl inside {CTL_POS, CTL_SPD, CTL_TRQ})
        else $error("illegal control kind");
endmodule
bind sdid_top sdid_top_assertions u_chk (.clock_i(clock_i), .nrst_i(nrst_i), .apb_i(apb_i),
    .apb_o(apb_o), .di_pins_i(di_pins_i), .motor_speed_i(motor_speed_i),
    .analog_speed_i(analog_speed_i), .analog_torque_i(analog_torque_i), .cmd_o(cmd_o));
`default_nettype wire

// *** bench/sdid_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module sdid_host_model (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [4:0] drive_i,
    input wire logic [2:0] open_i,
    output logic [7:0] pins_o
);
    logic [7:0] pins_r;
    logic [7:0] pins_nxt;
    always_comb begin
        pins_nxt = {~open_i[0], ~open_i[2], ~open_i[1], drive_i};
    end
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pins_r <= 8'hE0;
        end else begin
            pins_r <= pins_nxt;
        end
    end
    assign pins_o = pins_r;
endmodule
`default_nettype wire

// *** bench/servo_digital_input_decoder_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module servo_digital_input_decoder_tb;
    import sdid_pkg::*;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    sdid_apb_req_t apb_i = '0;
    sdid_apb_rsp_t apb_o;
    sdid_cmd_t cmd_o;
    logic [7:0] pins;
    logic [15:0] spd_i = 16'hFFFD;
    logic [15:0] ana_s = 16'h0000;
    logic [15:0] ana_t = 16'h0000;
    logic [4:0] drive = '0;
    logic [2:0] open = '0;
    logic [31:0] seed = 32'h0000_0F95;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int pre[4];
    always #4 clock_i = ~clock_i;
    sdid_top u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .apb_i(apb_i), .apb_o(apb_o),
        .di_pins_i(pins), .motor_speed_i(spd_i), .analog_speed_i(ana_s),
        .analog_torque_i(ana_t), .cmd_o(cmd_o));
    sdid_host_model u_host (.clock_i(clock_i), .nrst_i(nrst_i), .drive_i(drive),
        .open_i(open), .pins_o(pins));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic fld(input int f);
        case (f)
            0: return cmd_o.direction_invert;
            1: return cmd_o.torque_limit_valid;
            2: return cmd_o.speed_limit_valid;
            3: return cmd_o.jog_fwd;
            4: return cmd_o.jog_rev;
            5: return cmd_o.pulse_inhibit;
            6: return cmd_o.position_hold;
            7: return cmd_o.pulse_clear;
            8: return cmd_o.rev_torque_limit;
            9: return cmd_o.fwd_torque_limit;
            10: return cmd_o.ctl == CTL_POS;
            12: return cmd_o.gain_switch;
            default: return cmd_o.ctl == CTL_TRQ;
        endcase
    endfunction
    task automatic close_out();
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        apb_i <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock_i);
        apb_i.penable <= 1'b1;
        do @(posedge clock_i); while (apb_o.pready !== 1'b1);
        q = apb_o.prdata;
        e = apb_o.pslverr;
        apb_i <= '0;
        @(posedge clock_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    task automatic settle();
        repeat (8) @(posedge clock_i);
    endtask
    task automatic pin(input int b, input logic v);
        drive[b] <= v;
        settle();
    endtask
    task automatic lvl(input logic [5:0] c, input logic [7:0] code, input int f, input logic en);
        wr(REG_CTRL, {26'h0, c});
        wr(REG_ASSIGN_BASE + 8'h04, {23'h0, 1'b1, code});
        for (int v = 1; v >= 0; v--) begin
            pin(1, v[0]);
            chk({31'h0, fld(f)}, {31'h0, en & v[0]});
        end
    endtask
    task automatic sel(input logic [5:0] c, input logic [7:0] lo, input logic [7:0] base,
                       input int k, input logic z);
        logic [31:0] x;
        logic [15:0] g;
        wr(REG_CTRL, {26'h0, c});
        wr(REG_ASSIGN_BASE + 8'h08, {23'h0, 1'b1, lo});
        wr(REG_ASSIGN_BASE + 8'h0C, {23'h0, 1'b1, lo + 8'h01});
        for (int i = 0; i < 4; i++) begin
            pre[i] = int'(xs() & 32'h0000_FFFF);
            if (k == 2 || i < 3) wr(base + 8'(4 * i), 32'(pre[i]));
        end
        for (int i = 0; i < 4; i++) begin
            drive[2] <= i[0];
            drive[3] <= i[1];
            settle();
            if (k == 2) x = 32'(pre[i]);
            else if (i > 0) x = 32'(pre[i - 1]);
            else x = z ? 32'h0000_0000 : {16'h0, (k == 1) ? ana_t : ana_s};
            g = (k == 0) ? cmd_o.speed_cmd : (k == 1) ? cmd_o.torque_cmd : cmd_o.gear_numerator;
            chk({16'h0, g}, x);
        end
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        ana_s <= 16'(xs());
        ana_t <= 16'(xs());
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        rd(REG_CTRL, 32'h0000_0000, 1'b0);
        rd(REG_ZERO_RANGE, 32'h0000_000A, 1'b0);
        for (int i = 0; i < 8; i++) begin
            rd(REG_ASSIGN_BASE + 8'(4 * i), {23'h0, ASSIGN_RST[i]}, 1'b0);
        end
        rd(REG_GEAR_BASE, 32'h0000_0001, 1'b0);
        rd(8'h80, 32'h0000_0000, 1'b1);
        pin(4, 1'b1);
        pin(4, 1'b0);
        pin(0, 1'b1);
        chk({31'h0, cmd_o.servo_ready}, 32'h0000_0001);
        for (int k = 0; k < 3; k++) begin
            open[k] <= 1'b1;
            settle();
            chk({27'h0, cmd_o.fault_flags, cmd_o.fault_indication, cmd_o.servo_ready},
                {27'h0, 3'(1 << k), 2'b10});
            open[k] <= 1'b0;
            settle();
            chk({31'h0, cmd_o.fault_indication}, 32'h0000_0001);
            pin(4, 1'b1);
            pin(4, 1'b0);
            chk({27'h0, cmd_o.fault_flags, cmd_o.fault_indication, cmd_o.servo_ready},
                32'h0000_0001);
        end
        wr(REG_ASSIGN_BASE, {23'h0, 1'b0, FN_SERVO_ENABLE});
        pin(0, 1'b0);
        chk({31'h0, cmd_o.servo_ready}, 32'h0000_0001);
        pin(0, 1'b1);
        chk({31'h0, cmd_o.servo_ready}, 32'h0000_0000);
        lvl(6'h02, FN_CMD_INVERT, 0, 1'b1);
        lvl(6'h01, FN_TRQ_LIMIT_EN, 1, 1'b1);
        lvl(6'h02, FN_SPD_LIMIT_EN, 2, 1'b1);
        lvl(6'h00, FN_FWD_JOG, 3, 1'b1);
        lvl(6'h00, FN_REV_JOG, 4, 1'b1);
        lvl(6'h00, FN_PULSE_INHIBIT, 5, 1'b1);
        lvl(6'h00, FN_ZERO_CLAMP, 6, 1'b1);
        spd_i <= 16'h000A;
        lvl(6'h00, FN_ZERO_CLAMP, 6, 1'b0);
        lvl(6'h08, FN_PULSE_CLEAR, 7, 1'b1);
        lvl(6'h00, FN_PULSE_CLEAR, 7, 1'b0);
        lvl(6'h00, FN_GAIN_SWITCH, 12, 1'b1);
        lvl(6'h20, FN_REV_TRQ_LIMIT, 8, 1'b1);
        lvl(6'h20, FN_FWD_TRQ_LIMIT, 9, 1'b1);
        lvl(6'h00, FN_REV_TRQ_LIMIT, 8, 1'b0);
        lvl(6'h05, FN_SW_POS_SPD, 10, 1'b1);
        lvl(6'h06, FN_SW_TRQ_POS, 10, 1'b1);
        lvl(6'h07, FN_SW_SPD_TRQ, 11, 1'b1);
        sel(6'h01, FN_SPD_SEL_LO, REG_SPD_BASE, 0, 1'b0);
        sel(6'h03, FN_SPD_SEL_LO, REG_SPD_BASE, 0, 1'b1);
        sel(6'h02, FN_TRQ_SEL_LO, REG_TRQ_BASE, 1, 1'b0);
        sel(6'h04, FN_TRQ_SEL_LO, REG_TRQ_BASE, 1, 1'b1);
        sel(6'h00, FN_GEAR_SEL_LO, REG_GEAR_BASE, 2, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
